// >>> hw/btpwr_pkg.sv
// constants and types shared by the bluetooth power handshake controller
`default_nettype none
package btpwr_pkg;
  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned REF_CLK_PERIOD_NS = 100;
  localparam int unsigned POWERUP_NS = 1000;
  localparam int unsigned POWERUP_CYC =
    (POWERUP_NS + REF_CLK_PERIOD_NS - 1) / REF_CLK_PERIOD_NS;

  // ************************************************************
  // widths, field values and reset values
  // ************************************************************
  localparam int unsigned PAD_FUNC_W = 3;
  localparam logic [PAD_FUNC_W-1:0] PAD_FUNC_HANDSHAKE = 3'h0;
  localparam int unsigned SNIFF_W = 16;
  localparam int unsigned SYNC_IDX_DEV_WAKE = 0;
  localparam int unsigned SYNC_IDX_LPO = 1;
  localparam logic RST_PD = 1'b1;
  localparam logic RST_OE_N = 1'b1;
  localparam logic RST_CLK_REQ = 1'b0;

  // ************************************************************
  // power states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_POWERUP = 3'h0,
    ST_ACTIVE = 3'h1,
    ST_SLEEP = 3'h2,
    ST_SNIFF = 3'h3,
    ST_SHUTDOWN = 3'h4
  } btpwr_state_e;
endpackage
`default_nettype wire

// >>> hw/btpwr_sync_if.sv
// interface carrying raw pin levels to the synchroniser and clean levels back
`timescale 1ns/1ps
`default_nettype none
interface btpwr_sync_if #(parameter int unsigned W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  modport user (output raw, input lvl, input rise);
  modport sync (input raw, output lvl, output rise);
endinterface
`default_nettype wire

// >>> hw/btpwr_sync.sv
// two-flop synchroniser with rising-edge detect for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module btpwr_sync #(
  parameter int unsigned W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  btpwr_sync_if.sync bus
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] lvl_r;
  logic [W-1:0] lvl_nxt;
  logic [W-1:0] old_r;
  logic [W-1:0] old_nxt;

  if (W < 1) begin : g_bad_width
    $error("btpwr_sync: W must be at least 1");
  end

  // meta_r feeds lvl_r only; edges are taken between the clean stages
  always_comb begin
    if (i_rst) begin
      meta_nxt = '0;
      lvl_nxt = '0;
      old_nxt = '0;
    end else begin
      meta_nxt = bus.raw;
      lvl_nxt = meta_r;
      old_nxt = lvl_r;
    end
  end

  always_ff @(posedge i_clk) begin
    meta_r <= meta_nxt;
    lvl_r <= lvl_nxt;
    old_r <= old_nxt;
  end

  assign bus.lvl = lvl_r;
  assign bus.rise = lvl_r & ~old_r;
endmodule // btpwr_sync
`default_nettype wire

// >>> hw/btpwr_ctrl.sv
// bluetooth power handshake and rf power-down controller
`timescale 1ns/1ps
`default_nettype none
module btpwr_ctrl #(
  parameter int unsigned SNIFF_W = btpwr_pkg::SNIFF_W,
  parameter int unsigned POWERUP_CYCLES = btpwr_pkg::POWERUP_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_UART_MODE,
  input wire logic I_HS_EN,
  input wire logic [btpwr_pkg::PAD_FUNC_W-1:0] I_PAD_FUNC,
  input wire logic I_DEV_WAKE_POL,
  input wire logic I_HOST_WAKE_POL,
  input wire logic I_DEVICE_WAKE_IN,
  input wire logic I_LOW_POWER_OSC_IN,
  input wire logic I_SLEEP_OK,
  input wire logic I_HOST_ATTN,
  input wire logic I_BT_CLK_REQ,
  input wire logic I_WLAN_CLK_REQ,
  input wire logic I_TX_PKT,
  input wire logic I_RX_PKT,
  input wire logic I_SNIFF_EN,
  input wire logic [SNIFF_W-1:0] I_SNIFF_TICKS,
  input wire logic I_SHUTDOWN,
  input wire logic I_FM_EN,
  output logic O_TX_PD,
  output logic O_RX_PD,
  output logic O_PLL_PD,
  output logic O_PA_PD,
  output logic O_HOST_WAKE_OUT,
  output logic O_HOST_WAKE_OE_N,
  output logic O_CLK_REQ,
  output logic O_CLK_REQ_OE_N,
  output logic O_ON_LPO,
  output logic O_FM_ON,
  output logic O_INPUTS_EN,
  output logic O_SNIFF_WAKE,
  output logic O_DEV_WAKE_ACT,
  output logic [2:0] O_STATE
);
  localparam int unsigned PU_W = $clog2(POWERUP_CYCLES + 1);
  localparam logic [PU_W-1:0] PU_LAST = PU_W'(POWERUP_CYCLES - 1);

  if (SNIFF_W < 1 || POWERUP_CYCLES < 1) begin : g_bad_param
    $error("btpwr_ctrl: SNIFF_W and POWERUP_CYCLES must be at least 1");
  end

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  btpwr_sync_if #(.W(2)) u_sync_if ();
  assign u_sync_if.raw = {I_LOW_POWER_OSC_IN, I_DEVICE_WAKE_IN};

  btpwr_sync #(.W(2)) u_sync (
    .i_clk(I_REF_CLK),
    .i_rst(I_SYS_RST),
    .bus(u_sync_if.sync)
  );

  // ************************************************************
  // handshake qualification
  // ************************************************************
  btpwr_pkg::btpwr_state_e state_r;
  btpwr_pkg::btpwr_state_e state_nxt;
  logic hs_act;
  logic dw_act;
  logic lpo_tick;
  logic live;

  // pins act as handshake only on uart with handshake enabled and pad function zero
  assign hs_act = I_UART_MODE && I_HS_EN
                  && (I_PAD_FUNC == btpwr_pkg::PAD_FUNC_HANDSHAKE);
  // inputs are ignored in shutdown so a floating host line cannot wake us
  assign live = (state_r != btpwr_pkg::ST_SHUTDOWN);
  assign dw_act = hs_act && live
                  && (u_sync_if.lvl[btpwr_pkg::SYNC_IDX_DEV_WAKE] ^ ~I_DEV_WAKE_POL);
  assign lpo_tick = u_sync_if.rise[btpwr_pkg::SYNC_IDX_LPO];

  // ************************************************************
  // power state machine
  // ************************************************************
  logic [PU_W-1:0] pu_cnt_r;
  logic [PU_W-1:0] pu_cnt_nxt;
  logic [SNIFF_W-1:0] tmr_r;
  logic [SNIFF_W-1:0] tmr_nxt;
  logic swake_r;
  logic swake_nxt;

  always_comb begin
    state_nxt = state_r;
    pu_cnt_nxt = pu_cnt_r;
    tmr_nxt = tmr_r;
    swake_nxt = 1'b0;
    if (I_SYS_RST) begin
      state_nxt = btpwr_pkg::ST_POWERUP;
      pu_cnt_nxt = '0;
      tmr_nxt = '0;
    end else if (I_SHUTDOWN) begin
      state_nxt = btpwr_pkg::ST_SHUTDOWN;
      pu_cnt_nxt = '0;
      tmr_nxt = '0;
    end else begin
      case (state_r)
        btpwr_pkg::ST_POWERUP: begin
          if (pu_cnt_r == PU_LAST) begin
            state_nxt = btpwr_pkg::ST_ACTIVE;
          end else begin
            pu_cnt_nxt = pu_cnt_r + 1'b1;
          end
        end
        btpwr_pkg::ST_ACTIVE: begin
          if (!dw_act && I_SLEEP_OK) begin
            if (I_SNIFF_EN) begin
              state_nxt = btpwr_pkg::ST_SNIFF;
              tmr_nxt = I_SNIFF_TICKS;
            end else begin
              state_nxt = btpwr_pkg::ST_SLEEP;
            end
          end
        end
        btpwr_pkg::ST_SLEEP: begin
          if (dw_act || !I_SLEEP_OK) begin
            state_nxt = btpwr_pkg::ST_ACTIVE;
          end
        end
        btpwr_pkg::ST_SNIFF: begin
          // period counted in lpo edges, the only clock alive while parked
          if (dw_act) begin
            state_nxt = btpwr_pkg::ST_ACTIVE;
          end else if (lpo_tick) begin
            if (tmr_r == '0) begin
              state_nxt = btpwr_pkg::ST_ACTIVE;
              swake_nxt = 1'b1;
            end else begin
              tmr_nxt = tmr_r - 1'b1;
            end
          end
        end
        btpwr_pkg::ST_SHUTDOWN: begin
          // nothing survives: counters were cleared on entry, restart cold
          state_nxt = btpwr_pkg::ST_POWERUP;
        end
        default: begin
          state_nxt = btpwr_pkg::ST_POWERUP;
        end
      endcase
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    state_r <= state_nxt;
    pu_cnt_r <= pu_cnt_nxt;
    tmr_r <= tmr_nxt;
    swake_r <= swake_nxt;
  end

  // ************************************************************
  // registered outputs
  // ************************************************************
  logic awake;
  logic tx_pd_nxt;
  logic rx_pd_nxt;
  logic pll_pd_nxt;
  logic pa_pd_nxt;
  logic hw_nxt;
  logic hw_oe_n_nxt;
  logic cr_nxt;
  logic cr_oe_n_nxt;
  logic lpo_nxt;
  logic fm_nxt;
  logic tx_pd_r;
  logic rx_pd_r;
  logic pll_pd_r;
  logic pa_pd_r;
  logic hw_r;
  logic hw_oe_n_r;
  logic cr_r;
  logic cr_oe_n_r;
  logic lpo_r;
  logic fm_r;
  logic inen_r;
  logic dwa_r;

  assign awake = (state_r == btpwr_pkg::ST_ACTIVE);

  always_comb begin
    if (I_SYS_RST) begin
      tx_pd_nxt = btpwr_pkg::RST_PD;
      rx_pd_nxt = btpwr_pkg::RST_PD;
      pll_pd_nxt = btpwr_pkg::RST_PD;
      pa_pd_nxt = btpwr_pkg::RST_PD;
      hw_nxt = ~I_HOST_WAKE_POL;
      hw_oe_n_nxt = btpwr_pkg::RST_OE_N;
      cr_nxt = btpwr_pkg::RST_CLK_REQ;
      cr_oe_n_nxt = btpwr_pkg::RST_OE_N;
      lpo_nxt = 1'b0;
      fm_nxt = 1'b0;
    end else begin
      // rf blocks powered only while a packet is in flight
      tx_pd_nxt = !(awake && I_TX_PKT);
      rx_pd_nxt = !(awake && I_RX_PKT);
      pll_pd_nxt = !(awake && (I_TX_PKT || I_RX_PKT));
      pa_pd_nxt = !(awake && I_TX_PKT);
      hw_nxt = (hs_act && live && I_HOST_ATTN) ^ ~I_HOST_WAKE_POL;
      hw_oe_n_nxt = !(live && hs_act);
      cr_nxt = live && (I_BT_CLK_REQ || I_WLAN_CLK_REQ);
      cr_oe_n_nxt = !live;
      lpo_nxt = (state_r == btpwr_pkg::ST_SNIFF)
                || (state_r == btpwr_pkg::ST_SLEEP);
      // fm has no parked state, just on or off
      fm_nxt = live && (state_r != btpwr_pkg::ST_POWERUP) && I_FM_EN;
    end
  end

  always_ff @(posedge I_REF_CLK) begin
    tx_pd_r <= tx_pd_nxt;
    rx_pd_r <= rx_pd_nxt;
    pll_pd_r <= pll_pd_nxt;
    pa_pd_r <= pa_pd_nxt;
    hw_r <= hw_nxt;
    hw_oe_n_r <= hw_oe_n_nxt;
    cr_r <= cr_nxt;
    cr_oe_n_r <= cr_oe_n_nxt;
    lpo_r <= lpo_nxt;
    fm_r <= fm_nxt;
    inen_r <= !I_SYS_RST && live;
    dwa_r <= !I_SYS_RST && dw_act;
  end

  assign O_TX_PD = tx_pd_r;
  assign O_RX_PD = rx_pd_r;
  assign O_PLL_PD = pll_pd_r;
  assign O_PA_PD = pa_pd_r;
  assign O_HOST_WAKE_OUT = hw_r;
  assign O_HOST_WAKE_OE_N = hw_oe_n_r;
  assign O_CLK_REQ = cr_r;
  assign O_CLK_REQ_OE_N = cr_oe_n_r;
  assign O_ON_LPO = lpo_r;
  assign O_FM_ON = fm_r;
  assign O_INPUTS_EN = inen_r;
  assign O_SNIFF_WAKE = swake_r;
  assign O_DEV_WAKE_ACT = dwa_r;
  assign O_STATE = state_r;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_SYS_RST);

  property p_rf_in_packet;
    awake && I_TX_PKT |=> !O_TX_PD && !O_PA_PD && !O_PLL_PD;
  endproperty
  a_rf_in_packet: assert property (p_rf_in_packet) else $error("rf not on in tx packet");

  property p_rf_off_idle;
    !awake || !(I_TX_PKT || I_RX_PKT) |=> O_TX_PD && O_RX_PD && O_PLL_PD && O_PA_PD;
  endproperty
  a_rf_off_idle: assert property (p_rf_off_idle) else $error("rf on outside packet");

  property p_hs_gate;
    !hs_act |=> O_HOST_WAKE_OE_N && (O_HOST_WAKE_OUT == ~$past(I_HOST_WAKE_POL));
  endproperty
  a_hs_gate: assert property (p_hs_gate) else $error("handshake used while disabled");

  property p_stay_awake;
    dw_act && !I_SHUTDOWN && state_r != btpwr_pkg::ST_POWERUP
      |=> awake;
  endproperty
  a_stay_awake: assert property (p_stay_awake) else $error("slept with device wake held");

  property p_sleep_gate;
    awake && !I_SLEEP_OK && !I_SHUTDOWN |=> awake;
  endproperty
  a_sleep_gate: assert property (p_sleep_gate) else $error("slept without criteria");

  property p_host_wake;
    hs_act && live && I_HOST_ATTN |=> O_HOST_WAKE_OUT == $past(I_HOST_WAKE_POL);
  endproperty
  a_host_wake: assert property (p_host_wake) else $error("host wake not asserted");

  property p_clk_req;
    live |=> O_CLK_REQ == $past(I_BT_CLK_REQ || I_WLAN_CLK_REQ);
  endproperty
  a_clk_req: assert property (p_clk_req) else $error("clock request wrong");

  property p_clk_req_rst;
    @(posedge I_REF_CLK) disable iff (1'b0) I_SYS_RST |=> !O_CLK_REQ;
  endproperty
  a_clk_req_rst: assert property (p_clk_req_rst) else $error("clock request in reset");

  property p_sniff_wake;
    state_r == btpwr_pkg::ST_SNIFF && lpo_tick && tmr_r == '0 && !dw_act && !I_SHUTDOWN
      |=> awake && O_SNIFF_WAKE && $past(O_ON_LPO);
  endproperty
  a_sniff_wake: assert property (p_sniff_wake) else $error("sniff self wake missed");

  property p_shutdown_pins;
    !live |=> O_HOST_WAKE_OE_N && O_CLK_REQ_OE_N && !O_INPUTS_EN && !O_FM_ON;
  endproperty
  a_shutdown_pins: assert property (p_shutdown_pins) else $error("pins live in shutdown");

  property p_cold_restart;
    !live && !I_SHUTDOWN |=> state_r == btpwr_pkg::ST_POWERUP && pu_cnt_r == '0 && tmr_r == '0;
  endproperty
  a_cold_restart: assert property (p_cold_restart) else $error("state kept over shutdown");

  property p_fm_two_state;
    awake |=> O_FM_ON == $past(I_FM_EN);
  endproperty
  a_fm_two_state: assert property (p_fm_two_state) else $error("fm power wrong");

  c_sniff_wake: cover property (O_SNIFF_WAKE);
  c_sleep: cover property (awake ##1 state_r == btpwr_pkg::ST_SLEEP);
  c_restart: cover property (!live ##1 state_r == btpwr_pkg::ST_POWERUP);
  c_host_wake: cover property (hs_act && I_HOST_ATTN ##1 O_HOST_WAKE_OUT);
endmodule // btpwr_ctrl
`default_nettype wire

// >>> tb/btpwr_host_model.sv
// host-side model of the wake handshake pins
`timescale 1ns/1ps
`default_nettype none
module btpwr_host_model (
  input wire logic i_want_dev_wake,
  input wire logic i_dev_pol,
  input wire logic i_host_wake,
  input wire logic i_host_wake_oe_n,
  input wire logic i_host_pol,
  output logic o_dev_wake,
  output logic o_host_awake
);
  // the host always drives its wake pin, so the level is never stale
  assign o_dev_wake = i_want_dev_wake ~^ i_dev_pol;
  // a released pin cannot keep the host awake
  assign o_host_awake = !i_host_wake_oe_n && (i_host_wake == i_host_pol);
endmodule // btpwr_host_model
`default_nettype wire

// >>> tb/tb_top.sv
// self-checking bench for the power handshake controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int unsigned PU = 2;
  logic clk = 1'b0, rst = 1'b1, uart = 1'b0, hs_en = 1'b0, dpol = 1'b1, hpol = 1'b1;
  logic want = 1'b0, low_power_osc_in = 1'b0, sok = 1'b0, attn = 1'b0, btr = 1'b0, wlr = 1'b0;
  logic tx = 1'b0, rx = 1'b0, snen = 1'b0, shdn = 1'b0, fmen = 1'b0, act;
  logic [2:0] pad = 3'h0;
  logic [15:0] ticks = 16'h0003;
  wire logic dwake, awake, tx_pd, rx_pd, pll_pd, pa_pd, hw, hw_oe_n, cr, cr_oe_n;
  wire logic on_lpo, fm_on, in_en, sn_wake, dw_act;
  wire logic [2:0] state;
  int errors = 0, n_tests = 0, cycles = 0, nwake = 0, i;
  int seed = 32'h12d6;

  always #50 clk = ~clk;

  btpwr_ctrl #(.POWERUP_CYCLES(PU)) i_btpwr_ctrl (
    .I_REF_CLK(clk), .I_SYS_RST(rst), .I_UART_MODE(uart), .I_HS_EN(hs_en),
    .I_PAD_FUNC(pad), .I_DEV_WAKE_POL(dpol), .I_HOST_WAKE_POL(hpol),
    .I_DEVICE_WAKE_IN(dwake), .I_LOW_POWER_OSC_IN(low_power_osc_in), .I_SLEEP_OK(sok),
    .I_HOST_ATTN(attn), .I_BT_CLK_REQ(btr), .I_WLAN_CLK_REQ(wlr), .I_TX_PKT(tx),
    .I_RX_PKT(rx), .I_SNIFF_EN(snen), .I_SNIFF_TICKS(ticks), .I_SHUTDOWN(shdn),
    .I_FM_EN(fmen), .O_TX_PD(tx_pd), .O_RX_PD(rx_pd), .O_PLL_PD(pll_pd),
    .O_PA_PD(pa_pd), .O_HOST_WAKE_OUT(hw), .O_HOST_WAKE_OE_N(hw_oe_n),
    .O_CLK_REQ(cr), .O_CLK_REQ_OE_N(cr_oe_n), .O_ON_LPO(on_lpo), .O_FM_ON(fm_on),
    .O_INPUTS_EN(in_en), .O_SNIFF_WAKE(sn_wake), .O_DEV_WAKE_ACT(dw_act),
    .O_STATE(state));

  btpwr_host_model i_btpwr_host_model (
    .i_want_dev_wake(want), .i_dev_pol(dpol), .i_host_wake(hw),
    .i_host_wake_oe_n(hw_oe_n), .i_host_pol(hpol), .o_dev_wake(dwake),
    .o_host_awake(awake));

  function automatic logic [3:0] f_rf(input logic t, input logic r);
    return {!t, !r, !(t | r), !t};
  endfunction

  task automatic chk(input logic [4:0] seen, input logic [4:0] exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wait_state(input logic [2:0] s, input int lim);
    int k;
    for (k = 0; k < lim && state !== s; k++) cyc(1);
    chk({2'h0, state}, {2'h0, s});
  endtask

  task automatic lpo_pulse();
    low_power_osc_in = 1'b1;
    cyc(4);
    low_power_osc_in = 1'b0;
    cyc(4);
  endtask

  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // guard against a hang in any bounded wait
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  always @(negedge clk) if (sn_wake === 1'b1) nwake++;

  initial begin
    cyc(10);
    chk({1'b0, tx_pd, rx_pd, pll_pd, pa_pd}, 5'h0f);
    chk({cr, hw_oe_n, cr_oe_n, in_en, fm_on}, 5'h0c);
    rst = 1'b0;
    cyc(1);
    chk({2'h0, state}, 5'h00);
    wait_state(3'h1, PU + 3);
    chk({3'h0, cr_oe_n, in_en}, 5'h01);
    // random traffic on the rf, clock request, fm and host wake inputs
    for (i = 0; i < 200; i++) begin
      {tx, rx, btr, wlr, attn, uart, hs_en, hpol} = 8'($random(seed));
      fmen = 1'($random(seed));
      pad = ($random(seed) & 1) ? 3'h0 : 3'($random(seed));
      act = uart & hs_en & (pad == 3'h0);
      cyc(2);
      chk({1'b0, tx_pd, rx_pd, pll_pd, pa_pd}, {1'b0, f_rf(tx, rx)});
      chk({4'h0, cr}, {4'h0, btr | wlr});
      chk({3'h0, hw, hw_oe_n}, {3'h0, (act & attn) ~^ hpol, !act});
      chk({4'h0, awake}, {4'h0, act & attn});
      chk({4'h0, fm_on}, {4'h0, fmen});
    end
    {uart, hs_en, pad, tx, rx} = 7'h60;
    // sleep and wake under both device wake polarities
    for (i = 0; i < 2; i++) begin
      dpol = i[0];
      want = 1'b1;
      sok = 1'b1;
      cyc(6);
      chk({3'h0, state[0], dw_act}, 5'h03);
      want = 1'b0;
      wait_state(3'h2, 6);
      cyc(2);
      chk({4'h0, on_lpo}, 5'h01);
      want = 1'b1;
      wait_state(3'h1, 6);
    end
    snen = 1'b1;
    want = 1'b0;
    wait_state(3'h3, 6);
    nwake = 0;
    repeat (3) lpo_pulse();
    chk({2'h0, state}, 5'h03);
    chk(5'(nwake), 5'h00);
    lpo_pulse();
    chk(5'(nwake), 5'h01);
    {snen, sok, want} = 3'h1;
    wait_state(3'h1, 8);
    fmen = 1'b1;
    cyc(2);
    chk({4'h0, fm_on}, 5'h01);
    {btr, tx, shdn} = 3'h7;
    wait_state(3'h4, 4);
    cyc(2);
    chk({cr, hw_oe_n, cr_oe_n, in_en, fm_on}, 5'h0c);
    chk({1'b0, tx_pd, rx_pd, pll_pd, pa_pd}, 5'h0f);
    shdn = 1'b0;
    wait_state(3'h0, 3);
    chk({4'h0, dw_act}, 5'h00);
    wait_state(3'h1, PU + 3);
    cyc(2);
    chk({3'h0, fm_on, cr}, 5'h03);
    chk({3'h0, cr_oe_n, in_en}, 5'h01);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
